/* File: hdl/bcq_pkg.sv */
// Purpose: constants for the breakpoint compare qualifier
// Assumes: one clock, registers reached over avalon-mm
// Notes:   register index times four gives the byte address
// Notes on behaviour
// - trace mode forces first-address mask to zero
// - trace mode: second mask only in full
// - bits 7:6 mask first address high/low bytes
// - code x:0 with page: 20-bit compare
// - code x:0 without page: 16-bit compare
// - code 1:0 compares all address lines
// - code 1:1 matches whole page, page access needed
// - bits 5:4 mask comparator b address, dual
// - full mode: second mask masks data bytes
// - bit 3 adds direction to comparator a
// - bit 2: zero write, one read
// - break enable blocks setting trace enable
// - full mode: a matches address, b data
// - full mode ignores comparator b direction bits
package bcq_pkg;
    // ************************************************
    // register indices
    // ************************************************
    localparam logic [5:0] IDX_CTRL     = 6'h29;
    localparam logic [5:0] IDX_A_EXT    = 6'h2a;
    localparam logic [5:0] IDX_A_HIGH   = 6'h2b;
    localparam logic [5:0] IDX_A_LOW    = 6'h2c;
    localparam logic [5:0] IDX_B_EXT    = 6'h2d;
    localparam logic [5:0] IDX_B_HIGH   = 6'h2e;
    localparam logic [5:0] IDX_B_LOW    = 6'h2f;
    localparam logic [5:0] IDX_MODE     = 6'h30;
    localparam logic [5:0] IDX_STATUS   = 6'h31;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h32;

    // ************************************************
    // field positions
    // ************************************************
    localparam int CTL_A_MASK_H = 7;
    localparam int CTL_A_MASK_L = 6;
    localparam int CTL_B_MASK_H = 5;
    localparam int CTL_B_MASK_L = 4;
    localparam int CTL_A_DIR_EN = 3;
    localparam int CTL_A_DIR_V  = 2;
    localparam int CTL_B_DIR_EN = 1;
    localparam int CTL_B_DIR_V  = 0;
    localparam int MODE_BRK_EN  = 7;
    localparam int MODE_FULL    = 6;
    localparam int MODE_TRACE   = 0;
    localparam int ST_MATCH_A   = 0;
    localparam int ST_MATCH_B   = 1;
    localparam int ST_BREAK     = 2;
    localparam int ST_W         = 3;
    localparam int EXT_W        = 6;

    // ************************************************
    // mask codes and reset values
    // ************************************************
    localparam logic [1:0] MSK_NONE      = 2'h0;
    localparam logic [1:0] MSK_LOW_OFF   = 2'h1;
    localparam logic [1:0] MSK_HIGH_OFF  = 2'h2;
    localparam logic [1:0] MSK_PAGE_ONLY = 2'h3;
    localparam logic [7:0] RST_BYTE      = 8'h00;
    localparam logic [2:0] RST_ST        = 3'h0;

    typedef enum logic { BUS_IDLE, BUS_ACK } bcq_bus_t;
endpackage

/* File: hdl/bcq_cmp.sv */
// Purpose: one address or data comparator with mask and direction
// Assumes: inputs stable for the access cycle
// Notes:   purely combinational, owner registers the hit
`timescale 1ns/1ps
module bcq_cmp
(
    input  wire logic [5:0]  ext,
    input  wire logic [7:0]  high,
    input  wire logic [7:0]  low,
    input  wire logic [1:0]  mask,
    input  wire logic        data_mode,
    input  wire logic        dir_en,
    input  wire logic        dir_val,
    input  wire logic [15:0] bus_addr,
    input  wire logic [15:0] bus_data,
    input  wire logic [5:0]  bus_page,
    input  wire logic        page_sel,
    input  wire logic        bus_read,
    output logic             hit
);
    logic ext_ok;
    logic hi14;
    logic hi16;
    logic lo_ok;
    logic dh;
    logic dl;
    logic val_ok;
    logic dir_ok;

    assign ext_ok = (bus_page == ext);
    assign hi14   = (high[5:0] == bus_addr[13:8]);
    assign hi16   = (high == bus_addr[15:8]);
    assign lo_ok  = (low == bus_addr[7:0]);
    assign dh     = (high == bus_data[15:8]);
    assign dl     = (low == bus_data[7:0]);

    always_comb
    begin
        val_ok = 1'b0;
        if (data_mode)
        begin
            unique case (mask)
                bcq_pkg::MSK_NONE:      val_ok = dh & dl;
                bcq_pkg::MSK_LOW_OFF:   val_ok = dh;
                bcq_pkg::MSK_HIGH_OFF:  val_ok = dl;
                bcq_pkg::MSK_PAGE_ONLY: val_ok = 1'b1;
            endcase
        end
        else if (mask == bcq_pkg::MSK_PAGE_ONLY)
            val_ok = page_sel & ext_ok;
        else if (mask == bcq_pkg::MSK_LOW_OFF)
            val_ok = page_sel ? (ext_ok & hi14) : hi16;
        else
            val_ok = page_sel ? (ext_ok & hi14 & lo_ok) : (hi16 & lo_ok);
    end

    assign dir_ok = ~dir_en | (bus_read == dir_val);
    assign hit    = val_ok & dir_ok;
endmodule

/* File: hdl/bcq_qualifier.sv */
// Purpose: breakpoint compare qualifier with register slave
// Assumes: cpu bus inputs synchronous to ref_clk
// Notes:   avalon-mm slave, one wait state per access
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
module bcq_qualifier
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [15:0] cpu_addr,
    input  wire logic [15:0] cpu_data,
    input  wire logic [5:0]  program_page_index,
    input  wire logic        program_page_sel,
    input  wire logic        cpu_read,
    input  wire logic        cpu_valid,
    output logic             match_a_q,
    output logic             match_b_q,
    output logic             break_q,
    output logic             irq_q
);
    // ************************************************
    // registers
    // ************************************************
    logic [7:0]        ctrl_q;
    logic [7:0]        ext_q [2];
    logic [7:0]        high_q [2];
    logic [7:0]        low_q [2];
    logic              brk_en_q;
    logic              full_q;
    logic              trace_en_q;
    logic [2:0]        status_q;
    logic [2:0]        irq_mask_q;
    bcq_pkg::bcq_bus_t bus_q;

    logic              req;
    logic              addr_ok;
    logic [5:0]        idx;
    logic              wr_go;
    logic              rd_go;
    logic [7:0]        rd_byte;
    logic              trace_mode;
    logic              armed;
    logic [1:0]        mask_a;
    logic [1:0]        mask_b;
    logic [1:0]        mask [2];
    logic [1:0]        dir_en;
    logic [1:0]        dir_val;
    logic [1:0]        data_mode;
    logic [1:0]        hit;
    logic              ev_a;
    logic              ev_b;
    logic              ev_brk;
    logic [2:0]        ev;
    logic [2:0]        status_d;

    // ************************************************
    // bus decode
    // ************************************************
    assign req     = avs_read | avs_write;
    assign addr_ok = (avs_address[1:0] == 2'h0);
    assign idx     = avs_address[7:2];
    // the write lands on the edge the master sees waitrequest low
    assign wr_go   = ce & avs_write & (bus_q == bcq_pkg::BUS_ACK)
                     & addr_ok & avs_byteenable[0];
    assign rd_go   = ce & avs_read & (bus_q == bcq_pkg::BUS_IDLE);

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            bus_q           <= bcq_pkg::BUS_IDLE;
            avs_waitrequest <= 1'b1;
        end
        else if (ce)
        begin
            unique case (bus_q)
                bcq_pkg::BUS_IDLE:
                begin
                    if (req)
                    begin
                        bus_q           <= bcq_pkg::BUS_ACK;
                        avs_waitrequest <= 1'b0;
                    end
                end
                bcq_pkg::BUS_ACK:
                begin
                    bus_q           <= bcq_pkg::BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // ************************************************
    // read mux
    // ************************************************
    always_comb
    begin
        rd_byte = bcq_pkg::RST_BYTE;
        if (addr_ok)
        begin
            case (idx)
                bcq_pkg::IDX_CTRL:     rd_byte = ctrl_q;
                bcq_pkg::IDX_A_EXT:    rd_byte = ext_q[0];
                bcq_pkg::IDX_A_HIGH:   rd_byte = high_q[0];
                bcq_pkg::IDX_A_LOW:    rd_byte = low_q[0];
                bcq_pkg::IDX_B_EXT:    rd_byte = ext_q[1];
                bcq_pkg::IDX_B_HIGH:   rd_byte = high_q[1];
                bcq_pkg::IDX_B_LOW:    rd_byte = low_q[1];
                bcq_pkg::IDX_MODE:
                begin
                    rd_byte[bcq_pkg::MODE_BRK_EN] = brk_en_q;
                    rd_byte[bcq_pkg::MODE_FULL]   = full_q;
                    rd_byte[bcq_pkg::MODE_TRACE]  = trace_en_q;
                end
                bcq_pkg::IDX_STATUS:   rd_byte[2:0] = status_q;
                bcq_pkg::IDX_IRQ_MASK: rd_byte[2:0] = irq_mask_q;
                default:               rd_byte = bcq_pkg::RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            avs_readdata <= 32'h0000_0000;
        else if (rd_go)
            avs_readdata <= {24'h00_0000, rd_byte};
    end

    // ************************************************
    // control and comparator registers
    // ************************************************
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            ctrl_q <= bcq_pkg::RST_BYTE;
        else if (wr_go && idx == bcq_pkg::IDX_CTRL)
            ctrl_q <= avs_writedata[7:0];
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < 2; i++)
            begin
                ext_q[i]  <= bcq_pkg::RST_BYTE;
                high_q[i] <= bcq_pkg::RST_BYTE;
                low_q[i]  <= bcq_pkg::RST_BYTE;
            end
        end
        else if (wr_go)
        begin
            case (idx)
                bcq_pkg::IDX_A_EXT:  ext_q[0]  <= avs_writedata[7:0];
                bcq_pkg::IDX_A_HIGH: high_q[0] <= avs_writedata[7:0];
                bcq_pkg::IDX_A_LOW:  low_q[0]  <= avs_writedata[7:0];
                bcq_pkg::IDX_B_EXT:  ext_q[1]  <= avs_writedata[7:0];
                bcq_pkg::IDX_B_HIGH: high_q[1] <= avs_writedata[7:0];
                bcq_pkg::IDX_B_LOW:  low_q[1]  <= avs_writedata[7:0];
                default:             ;
            endcase
        end
    end

    // ************************************************
    // mode register
    // ************************************************
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            brk_en_q   <= 1'b0;
            full_q     <= 1'b0;
            trace_en_q <= 1'b0;
        end
        else if (wr_go && idx == bcq_pkg::IDX_MODE)
        begin
            brk_en_q   <= avs_writedata[bcq_pkg::MODE_BRK_EN];
            full_q     <= avs_writedata[bcq_pkg::MODE_FULL];
            trace_en_q <= avs_writedata[bcq_pkg::MODE_TRACE]
                          & ~avs_writedata[bcq_pkg::MODE_BRK_EN];
        end
    end

    // ************************************************
    // mask and direction qualification
    // ************************************************
    assign trace_mode = trace_en_q & ~brk_en_q;
    assign armed      = brk_en_q | trace_mode;

    assign mask_a = trace_mode ? bcq_pkg::MSK_NONE
                    : ctrl_q[bcq_pkg::CTL_A_MASK_H:bcq_pkg::CTL_A_MASK_L];
    // second mask, full only in trace
    assign mask_b = (trace_mode & ~full_q) ? bcq_pkg::MSK_NONE
                    : ctrl_q[bcq_pkg::CTL_B_MASK_H:bcq_pkg::CTL_B_MASK_L];
    assign mask[0] = mask_a;
    assign mask[1] = mask_b;

    assign dir_en[0]  = ctrl_q[bcq_pkg::CTL_A_DIR_EN];
    assign dir_val[0] = ctrl_q[bcq_pkg::CTL_A_DIR_V];
    assign dir_en[1]  = ctrl_q[bcq_pkg::CTL_B_DIR_EN] & ~full_q;
    assign dir_val[1] = ctrl_q[bcq_pkg::CTL_B_DIR_V];
    // b compares data in full mode
    assign data_mode  = {full_q, 1'b0};

    // ************************************************
    // comparators
    // ************************************************
    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_cmp
            bcq_cmp u_cmp
            (
                .ext       (ext_q[g][bcq_pkg::EXT_W-1:0]),
                .high      (high_q[g]),
                .low       (low_q[g]),
                .mask      (mask[g]),
                .data_mode (data_mode[g]),
                .dir_en    (dir_en[g]),
                .dir_val   (dir_val[g]),
                .bus_addr  (cpu_addr),
                .bus_data  (cpu_data),
                .bus_page  (program_page_index),
                .page_sel  (program_page_sel),
                .bus_read  (cpu_read),
                .hit       (hit[g])
            );
        end
    endgenerate

    // ************************************************
    // match events
    // ************************************************
    assign ev_a   = cpu_valid & armed & hit[0];
    assign ev_b   = cpu_valid & armed & hit[1];
    // full mode needs address and data together
    assign ev_brk = full_q ? (ev_a & ev_b) : (ev_a | ev_b);
    assign ev     = {ev_brk, ev_b, ev_a};

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            match_a_q <= 1'b0;
            match_b_q <= 1'b0;
            break_q   <= 1'b0;
        end
        else if (ce)
        begin
            match_a_q <= ev_a;
            match_b_q <= ev_b;
            break_q   <= ev_brk;
        end
    end

    // ************************************************
    // interrupt status and mask
    // ************************************************
    // a new event wins over a write-one-to-clear in the same cycle
    always_comb
    begin
        status_d = status_q;
        if (wr_go && idx == bcq_pkg::IDX_STATUS)
            status_d = status_q & ~avs_writedata[bcq_pkg::ST_W-1:0];
        status_d = status_d | ev;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            status_q <= bcq_pkg::RST_ST;
        else if (ce)
            status_q <= status_d;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            irq_mask_q <= bcq_pkg::RST_ST;
        else if (wr_go && idx == bcq_pkg::IDX_IRQ_MASK)
            irq_mask_q <= avs_writedata[bcq_pkg::ST_W-1:0];
    end

    // updated on the same edge as status, kept registered for a clean pin
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            irq_q <= 1'b0;
        else if (ce)
            irq_q <= |(status_d & irq_mask_q);
    end
endmodule

/* File: sim/bcq_qualifier_monitor.sv */
// Purpose: bus and match timing checks for the qualifier
// Assumes: ce held high, one clock domain
// Notes:   sees only top-level ports; register contents judged by the bench
`timescale 1ns/1ps
module bcq_qualifier_monitor
(
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        cpu_valid,
    input wire logic        match_a_q,
    input wire logic        match_b_q,
    input wire logic        break_q,
    input wire logic        irq_q
);
    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic unmapped;
    assign unmapped = avs_address[1:0] != 2'h0 || avs_address[7:2] < bcq_pkg::IDX_CTRL
                      || avs_address[7:2] > bcq_pkg::IDX_IRQ_MASK;
    // idle slave sees a fresh request
    sequence s_taken;
        ce && (avs_read || avs_write) && avs_waitrequest && $past(avs_waitrequest);
    endsequence
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    a_bus_answer_once: assert property (s_taken |=> s_answer)
        else $error("bus request not answered in one cycle");
    a_no_spurious_ack: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
        else $error("answer without request");
    a_upper_bits_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_unmapped_reads_zero: assert property (avs_read && !avs_waitrequest && unmapped |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_reset_quiet_out: assert property ($fell(rst) |-> avs_waitrequest && !match_a_q && !match_b_q
                                        && !break_q && !irq_q && avs_readdata == 32'h0)
        else $error("outputs not cleared by reset");
    a_hit_a_valid: assert property (match_a_q |-> $past(cpu_valid))
        else $error("comparator a hit without access");
    a_hit_b_valid: assert property (match_b_q |-> $past(cpu_valid))
        else $error("comparator b hit without access");
    a_break_has_source: assert property (break_q |-> match_a_q || match_b_q)
        else $error("break without comparator hit");
    a_break_both_hits: assert property (match_a_q && match_b_q |-> break_q)
        else $error("both hits without break");
endmodule

bind bcq_qualifier bcq_qualifier_monitor u_mon
(
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cpu_valid(cpu_valid), .match_a_q(match_a_q), .match_b_q(match_b_q), .break_q(break_q), .irq_q(irq_q)
);

/* File: sim/bcq_cpu_model.sv */
// Purpose: cpu core bus model driving one access per call
// Assumes: caller waits for the task to return
// Notes:   released bus shows the inverse, never a stale copy
`timescale 1ns/1ps
module bcq_cpu_model
(
    input  wire logic ref_clk,
    output logic [15:0] cpu_addr,
    output logic [15:0] cpu_data,
    output logic [5:0]  program_page_index,
    output logic        program_page_sel,
    output logic        cpu_read,
    output logic        cpu_valid
);
    initial
    begin
        cpu_addr = 16'h0;
        cpu_data = 16'h0;
        program_page_index = 6'h0;
        program_page_sel = 1'b0;
        cpu_read = 1'b0;
        cpu_valid = 1'b0;
    end
    task automatic access(input logic [15:0] a, input logic [15:0] d, input logic [5:0] p,
                          input logic s, input logic r);
        @(posedge ref_clk);
        cpu_addr <= a;
        cpu_data <= d;
        program_page_index <= p;
        program_page_sel <= s;
        cpu_read <= r;
        cpu_valid <= 1'b1;
        @(posedge ref_clk);
        cpu_addr <= ~a;
        cpu_data <= ~d;
        program_page_index <= ~p;
        program_page_sel <= ~s;
        cpu_read <= ~r;
        cpu_valid <= 1'b0;
    endtask
endmodule

/* File: sim/bcq_qualifier_tb.sv */
// Purpose: self-checking bench for the breakpoint compare qualifier
// Assumes: avalon-mm master tasks, cpu model on the far side
// Notes:   expectations queued by the driver, compared by the watcher
`timescale 1ns/1ps
module bcq_qualifier_tb;
    logic        ref_clk;
    logic        rst;
    logic        ce;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [15:0] cpu_addr;
    logic [15:0] cpu_data;
    logic [5:0]  program_page_index;
    logic        program_page_sel;
    logic        cpu_read;
    logic        cpu_valid;
    logic        match_a_q;
    logic        match_b_q;
    logic        break_q;
    logic        irq_q;
    logic        valid_q;
    logic [31:0] rd_notes[$];
    logic [2:0]  hit_notes[$];
    logic [7:0]  tg[6];
    logic [7:0]  modes[5] = '{8'h00, 8'h80, 8'hc0, 8'h01, 8'h41};
    logic [15:0] flips[4] = '{16'h0000, 16'h0001, 16'h0100, 16'h4000};
    logic [7:0]  mode;
    logic [7:0]  ctl;
    logic [31:0] v;
    int          mismatches;
    int          total_checks;
    int          seed;

    bcq_qualifier dut
    (
        .ref_clk(ref_clk), .rst(rst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cpu_addr(cpu_addr),
        .cpu_data(cpu_data), .program_page_index(program_page_index), .program_page_sel(program_page_sel),
        .cpu_read(cpu_read), .cpu_valid(cpu_valid), .match_a_q(match_a_q), .match_b_q(match_b_q),
        .break_q(break_q), .irq_q(irq_q)
    );
    bcq_cpu_model cpu
    (
        .ref_clk(ref_clk), .cpu_addr(cpu_addr), .cpu_data(cpu_data), .program_page_index(program_page_index),
        .program_page_sel(program_page_sel), .cpu_read(cpu_read), .cpu_valid(cpu_valid)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h0, d};
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 40);
        if (n >= 40)
            mismatches++;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        bus(1'b1, {i, 2'h0}, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_notes.push_back(e);
        bus(1'b0, a, 8'h0);
    endtask
    // full, 256-byte range and page-only address compare
    function automatic logic cmp(input logic [1:0] c, input logic [5:0] x, input logic [7:0] h,
                                 input logic [7:0] l, input logic [15:0] a, input logic [5:0] p, input logic s);
        logic pg;
        pg = s && p == x;
        case (c)
            2'h1: cmp = s ? pg && a[13:8] == h[5:0] : a[15:8] == h;
            2'h3: cmp = pg;
            default: cmp = s ? pg && a[13:0] == {h[5:0], l} : a == {h, l};
        endcase
    endfunction
    task automatic hit_one(input logic sb);
        logic [31:0] r;
        logic [15:0] a;
        logic [15:0] d;
        logic [5:0]  p;
        logic        ea;
        logic        eb;
        logic        tr;
        r = $random(seed);
        a = (sb ? {tg[4], tg[5]} : {tg[1], tg[2]}) ^ flips[r[1:0]];
        p = (sb ? tg[3][5:0] : tg[0][5:0]) ^ {5'h0, r[2] & r[3]};
        d = {tg[4], tg[5]} ^ flips[r[5:4]];
        // trace mode forces first mask, second mask only in full
        tr = mode[0] && !mode[7];
        ea = cmp(tr ? 2'h0 : ctl[7:6], tg[0][5:0], tg[1], tg[2], a, p, r[6]) && (!ctl[3] || r[7] == ctl[2]);
        if (mode[6])
            eb = (ctl[5] || d[15:8] == tg[4]) && (ctl[4] || d[7:0] == tg[5]);
        else
            eb = cmp(tr ? 2'h0 : ctl[5:4], tg[3][5:0], tg[4], tg[5], a, p, r[6]) && (!ctl[1] || r[7] == ctl[0]);
        ea = ea && (mode[7] || mode[0]);
        eb = eb && (mode[7] || mode[0]);
        hit_notes.push_back({ea, eb, mode[6] ? ea && eb : ea || eb});
        cpu.access(a, d, p, r[6], r[7]);
    endtask

    // ****************************************
    // result watcher
    // ****************************************
    always @(posedge ref_clk)
    begin
        valid_q <= cpu_valid && !rst;
        if (avs_read && avs_waitrequest === 1'b0 && rd_notes.size() > 0)
            chk("readdata", rd_notes.pop_front(), avs_readdata);
        if (valid_q && hit_notes.size() > 0)
            chk("matches", {29'h0, hit_notes.pop_front()}, {29'h0, match_a_q, match_b_q, break_q});
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        close_out();
    end

    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        seed = 15;
        mismatches = 0;
        total_checks = 0;
        valid_q = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        avs_address = 8'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h1;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 8'h29; i <= 8'h32; i++)
            rd(8'(i * 4), 32'h0);
        rd(8'hfc, 32'h0);
        rd(8'ha5, 32'h0);
        $display("test reset values done");
        v = $random(seed);
        wr(bcq_pkg::IDX_CTRL, v[7:0]);
        rd({bcq_pkg::IDX_CTRL, 2'h0}, {24'h0, v[7:0]});
        avs_byteenable <= 4'h0;
        wr(bcq_pkg::IDX_CTRL, ~v[7:0]);
        avs_byteenable <= 4'h1;
        rd({bcq_pkg::IDX_CTRL, 2'h0}, {24'h0, v[7:0]});
        wr(bcq_pkg::IDX_MODE, 8'h81);
        rd({bcq_pkg::IDX_MODE, 2'h0}, 32'h80);
        $display("test control access done");
        // trace mode last: exact breaks without aliasing
        for (int m = 0; m < 5; m++)
        begin
            mode = modes[m];
            wr(bcq_pkg::IDX_MODE, mode);
            for (int r = 0; r < 6; r++)
            begin
                v = $random(seed);
                ctl = v[7:0];
                wr(bcq_pkg::IDX_CTRL, ctl);
                for (int j = 0; j < 6; j++)
                begin
                    v = $random(seed);
                    tg[j] = v[7:0];
                    wr(6'(bcq_pkg::IDX_A_EXT + j), tg[j]);
                end
                for (int k = 0; k < 8; k++)
                    hit_one(k[0]);
            end
            $display("test mode %h done", mode);
        end
        wr(bcq_pkg::IDX_MODE, 8'h80);
        wr(bcq_pkg::IDX_CTRL, 8'hf0);
        wr(bcq_pkg::IDX_A_EXT, 8'h05);
        wr(bcq_pkg::IDX_B_EXT, 8'h06);
        wr(bcq_pkg::IDX_STATUS, 8'h07);
        wr(bcq_pkg::IDX_IRQ_MASK, 8'h00);
        hit_notes.push_back(3'h5);
        cpu.access(16'h1234, 16'h0, 6'h05, 1'b1, 1'b0);
        repeat (3) @(posedge ref_clk);
        chk("irq masked", 32'h0, {31'h0, irq_q});
        rd({bcq_pkg::IDX_STATUS, 2'h0}, 32'h5);
        wr(bcq_pkg::IDX_IRQ_MASK, 8'h01);
        repeat (3) @(posedge ref_clk);
        chk("irq raised", 32'h1, {31'h0, irq_q});
        wr(bcq_pkg::IDX_STATUS, 8'h01);
        repeat (3) @(posedge ref_clk);
        chk("irq cleared", 32'h0, {31'h0, irq_q});
        rd({bcq_pkg::IDX_STATUS, 2'h0}, 32'h4);
        $display("test interrupt done");
        repeat (4) @(posedge ref_clk);
        close_out();
    end
endmodule
